//--- flex_io_cfg_pkg.sv
// Constants shared by the flexible-port configuration loader
package flex_io_cfg_pkg;
  localparam logic [5:0] ADDR_INTERFACE_TIMING_CONTROL = 6'h01;
  localparam logic [5:0] ADDR_IO_FORMAT_INTERPOLATION  = 6'h13;
  localparam logic [5:0] ADDR_IO_MODE_SELECT           = 6'h14;
  localparam logic [7:0] RESET_INTERFACE_TIMING_CONTROL = 8'h00;
  localparam logic [7:0] RESET_IO_FORMAT_INTERPOLATION  = 8'h00;
  localparam logic [7:0] RESET_IO_MODE_SELECT           = 8'h00;
  localparam int TIMING_MODE_MSB      = 7;
  localparam int TIMING_MODE_LSB      = 5;
  localparam int INTERP_MSB           = 1;
  localparam int INTERP_LSB           = 0;
  localparam int DUPLEX_SELECT_BIT    = 4;
  localparam int BUS_WIDTH_BIT        = 2;
  localparam int LEGACY_COMPAT_BIT    = 0;
  localparam logic [1:0] INTERP_1X    = 2'h0;
  localparam logic [1:0] INTERP_2X    = 2'h1;
  localparam logic [1:0] INTERP_4X    = 2'h2;
  localparam logic [2:0] TIMING_STANDARD      = 3'h0;
  localparam logic [2:0] TIMING_OPT_FULL      = 3'h1;
  localparam logic [2:0] TIMING_OPT_PARALLEL  = 3'h3;
  localparam logic [2:0] TIMING_OPT_INTERLEAV = 3'h5;
  localparam logic [2:0] TIMING_CLONE         = 3'h7;
  localparam logic [3:0] SERIAL_INSTR_LAST    = 4'h7;
  localparam logic [3:0] SERIAL_WORD_LAST     = 4'hf;
endpackage

//--- serial_reg_port.sv
// Serial register port: 8-bit instruction then 8-bit data per frame
`timescale 1ns/100ps
module serial_reg_port
  import flex_io_cfg_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       enable_in,
  input  wire logic       select_in,
  input  wire logic       sclk_in,
  input  wire logic       sdi_in,
  input  wire logic [7:0] rd_data_in,
  output logic      [5:0] rd_addr_out,
  output logic      [5:0] wr_addr_out,
  output logic      [7:0] wr_data_out,
  output logic            wr_strobe_out,
  output logic            sdo_out,
  output logic            sdo_oe_out
);
  logic [3:0]  count_reg,   count_next;
  logic [14:0] shift_reg,   shift_next;
  logic [7:0]  out_reg,     out_next;
  logic        reading_reg, reading_next;
  logic        sclk_reg;
  logic [5:0]  wa_reg,      wa_next;
  logic [7:0]  wd_reg,      wd_next;
  logic        ws_reg,      ws_next;
  logic        rise;
  logic        fall;
  logic [15:0] word;

  ////////////////////////////////////////////////////////////////////////////
  assign rise        = sclk_in & ~sclk_reg;
  assign fall        = ~sclk_in & sclk_reg;
  assign word        = {shift_reg, sdi_in};
  assign rd_addr_out = word[5:0];

  always_comb begin
    count_next   = count_reg;
    shift_next   = shift_reg;
    out_next     = out_reg;
    reading_next = reading_reg;
    wa_next      = wa_reg;
    wd_next      = wd_reg;
    ws_next      = 1'b0;
    // Select high ends any frame, so a torn frame never writes
    if (!enable_in || select_in) begin
      count_next   = 4'h0;
      reading_next = 1'b0;
    end else if (rise) begin
      shift_next = word[14:0];
      count_next = count_reg + 4'h1;
      if (count_reg == SERIAL_INSTR_LAST && word[7]) begin
        reading_next = 1'b1;
        out_next     = rd_data_in;
      end
      if (count_reg == SERIAL_WORD_LAST) begin
        reading_next = 1'b0;
        if (!word[15]) begin
          ws_next = 1'b1;
          wa_next = word[13:8];
          wd_next = word[7:0];
        end
      end
    end else if (fall && reading_reg && count_reg != 4'h8) begin
      out_next = {out_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      count_reg   <= 4'h0;
      shift_reg   <= 15'h0;
      out_reg     <= 8'h00;
      reading_reg <= 1'b0;
      sclk_reg    <= 1'b0;
      wa_reg      <= 6'h00;
      wd_reg      <= 8'h00;
      ws_reg      <= 1'b0;
    end else begin
      count_reg   <= count_next;
      shift_reg   <= shift_next;
      out_reg     <= out_next;
      reading_reg <= reading_next;
      sclk_reg    <= sclk_in;
      wa_reg      <= wa_next;
      wd_reg      <= wd_next;
      ws_reg      <= ws_next;
    end
  end

  assign wr_addr_out   = wa_reg;
  assign wr_data_out   = wd_reg;
  assign wr_strobe_out = ws_reg;
  assign sdo_out       = out_reg[7];
  assign sdo_oe_out    = reading_reg;
endmodule

//--- flex_io_mode_config.sv
// Strap latch, register file and mode decode for the flexible data port
// Notes on behaviour
// - Latch ADC low-power strap at reset release; high means lower power.
// - Duplex strap latched at reset release, used only with serial port off.
// - Bus-width strap latched at reset, used only in strap half-duplex.
// - Half-duplex strap: width low is 20-bit parallel, high 10-bit.
// - Serial-enable strap low disables port; its pins become straps.
// - Serial-enable strap high enables port; duplex, width and interpolation straps ignored.
// - Strap interpolation 00/01/10 gives 1x/2x/4x, also PLL multiplier.
// - Receive power-down high stops ADC clock and cuts receive bias.
// - Transmit power-down high stops DAC clocks and cuts transmit bias.
// - Half-duplex direction low stops transmit clock; bus is receive.
// - Half-duplex direction high stops receive clocks; bus is input.
`timescale 1ns/100ps
module flex_io_mode_config
  import flex_io_cfg_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       adc_low_power_strap_in,
  input  wire logic       serial_select_pin_in,
  input  wire logic       serial_clock_pin_in,
  input  wire logic       serial_data_pin_in,
  input  wire logic       serial_out_pin_in,
  output logic            serial_out_pin_out,
  output logic            serial_out_pin_oe_out,
  input  wire logic       flex_control_pin_two_in,
  input  wire logic       receive_powerdown_pin_in,
  input  wire logic       transmit_powerdown_pin_in,
  input  wire logic       direction_pin_in,
  output logic            adc_low_power_out,
  output logic            serial_port_enabled_out,
  output logic            full_duplex_mode_out,
  output logic            half_duplex_parallel_mode_out,
  output logic            half_duplex_interleaved_mode_out,
  output logic            clone_mode_out,
  output logic      [2:0] timing_mode_out,
  output logic      [1:0] interp_factor_out,
  output logic      [1:0] pll_multiplier_out,
  output logic            interp_config_error_out,
  output logic            adc_clock_enable_out,
  output logic            rx_bias_enable_out,
  output logic            dac_clock_enable_out,
  output logic            tx_bias_enable_out,
  output logic            rx_digital_clock_enable_out,
  output logic            tx_digital_clock_enable_out,
  output logic            data_bus_drive_out
);
  logic       low_power_strap_reg, low_power_strap_next;
  logic       serial_en_strap_reg, serial_en_strap_next;
  logic       duplex_strap_reg,    duplex_strap_next;
  logic       width_strap_reg,     width_strap_next;
  logic [1:0] interp_strap_reg,    interp_strap_next;
  logic [7:0] timing_reg,          timing_next;
  logic [7:0] interp_reg,          interp_next;
  logic [7:0] mode_reg,            mode_next;
  logic [5:0] rd_addr;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_strobe;
  logic       full_next,  par_next, intl_next, clone_next;
  logic [1:0] factor_next;
  logic [2:0] tmode_next;
  logic       err_next;
  logic       half_duplex;
  logic [9:0] out_next_vec;

  function automatic logic [7:0] reg_read(input logic [5:0] addr,
                                          input logic [7:0] t,
                                          input logic [7:0] i,
                                          input logic [7:0] m);
    case (addr)
      ADDR_INTERFACE_TIMING_CONTROL: reg_read = t;
      ADDR_IO_FORMAT_INTERPOLATION:  reg_read = i;
      ADDR_IO_MODE_SELECT:           reg_read = m;
      default:                       reg_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial port lives only when the enable strap was high at reset
  serial_reg_port u_port (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .enable_in     (serial_en_strap_reg),
    .select_in     (serial_select_pin_in),
    .sclk_in       (serial_clock_pin_in),
    .sdi_in        (serial_data_pin_in),
    .rd_data_in    (reg_read(rd_addr, timing_reg, interp_reg, mode_reg)),
    .rd_addr_out   (rd_addr),
    .wr_addr_out   (wr_addr),
    .wr_data_out   (wr_data),
    .wr_strobe_out (wr_strobe),
    .sdo_out       (serial_out_pin_out),
    .sdo_oe_out    (serial_out_pin_oe_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Straps follow the pins while reset is high, so the last sample before
  // release is the one held: the last clock edge before reset falls
  always_comb begin
    low_power_strap_next = low_power_strap_reg;
    serial_en_strap_next = serial_en_strap_reg;
    duplex_strap_next    = duplex_strap_reg;
    width_strap_next     = width_strap_reg;
    interp_strap_next    = interp_strap_reg;
    if (reset_in) begin
      low_power_strap_next = adc_low_power_strap_in;
      serial_en_strap_next = serial_select_pin_in;
      duplex_strap_next    = serial_out_pin_in;
      width_strap_next     = flex_control_pin_two_in;
      interp_strap_next    = {serial_data_pin_in, serial_clock_pin_in};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    low_power_strap_reg <= low_power_strap_next;
    serial_en_strap_reg <= serial_en_strap_next;
    duplex_strap_reg    <= duplex_strap_next;
    width_strap_reg     <= width_strap_next;
    interp_strap_reg    <= interp_strap_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    timing_next = timing_reg;
    interp_next = interp_reg;
    mode_next   = mode_reg;
    if (wr_strobe) begin
      case (wr_addr)
        ADDR_INTERFACE_TIMING_CONTROL: timing_next = wr_data;
        ADDR_IO_FORMAT_INTERPOLATION:  interp_next = wr_data;
        ADDR_IO_MODE_SELECT:           mode_next   = wr_data;
        default:                       ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timing_reg <= RESET_INTERFACE_TIMING_CONTROL;
      interp_reg <= RESET_IO_FORMAT_INTERPOLATION;
      mode_reg   <= RESET_IO_MODE_SELECT;
    end else begin
      timing_reg <= timing_next;
      interp_reg <= interp_next;
      mode_reg   <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    clone_next = 1'b0;
    if (serial_en_strap_reg) begin
      clone_next  = mode_reg[LEGACY_COMPAT_BIT];
      full_next   = !clone_next && mode_reg[DUPLEX_SELECT_BIT];
      intl_next   = !clone_next && !full_next && mode_reg[BUS_WIDTH_BIT];
      par_next    = !clone_next && !full_next && !intl_next;
      factor_next = interp_reg[INTERP_MSB:INTERP_LSB];
      tmode_next  = timing_reg[TIMING_MODE_MSB:TIMING_MODE_LSB];
    end else begin
      full_next   = duplex_strap_reg;
      par_next    = !duplex_strap_reg && !width_strap_reg;
      intl_next   = !duplex_strap_reg && width_strap_reg;
      factor_next = interp_strap_reg;
      tmode_next  = TIMING_STANDARD;
    end
    // Interleaved modes cannot run at 1x; flag it rather than fix it up
    err_next = (full_next || intl_next || clone_next) &&
               (factor_next != INTERP_2X && factor_next != INTERP_4X);
  end

  assign half_duplex = !full_next;

  // Packed so one register stage serves every derived output
  assign out_next_vec = {
    full_next, par_next, intl_next, clone_next, err_next,
    !receive_powerdown_pin_in,
    !transmit_powerdown_pin_in,
    !(half_duplex && direction_pin_in),
    !(half_duplex && !direction_pin_in),
    !(half_duplex && direction_pin_in)
  };

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      full_duplex_mode_out             <= 1'b0;
      half_duplex_parallel_mode_out    <= 1'b0;
      half_duplex_interleaved_mode_out <= 1'b0;
      clone_mode_out                   <= 1'b0;
      interp_config_error_out          <= 1'b0;
      adc_clock_enable_out             <= 1'b0;
      dac_clock_enable_out             <= 1'b0;
      rx_digital_clock_enable_out      <= 1'b0;
      tx_digital_clock_enable_out      <= 1'b0;
      data_bus_drive_out               <= 1'b0;
      interp_factor_out                <= INTERP_1X;
      timing_mode_out                  <= TIMING_STANDARD;
    end else begin
      full_duplex_mode_out             <= out_next_vec[9];
      half_duplex_parallel_mode_out    <= out_next_vec[8];
      half_duplex_interleaved_mode_out <= out_next_vec[7];
      clone_mode_out                   <= out_next_vec[6];
      interp_config_error_out          <= out_next_vec[5];
      adc_clock_enable_out             <= out_next_vec[4];
      dac_clock_enable_out             <= out_next_vec[3];
      rx_digital_clock_enable_out      <= out_next_vec[2];
      tx_digital_clock_enable_out      <= out_next_vec[1];
      data_bus_drive_out               <= out_next_vec[0];
      interp_factor_out                <= factor_next;
      timing_mode_out                  <= tmode_next;
    end
  end

  // Bias follows the clocks; strap flags are plain flops of the straps
  assign rx_bias_enable_out      = adc_clock_enable_out;
  assign tx_bias_enable_out      = dac_clock_enable_out;
  assign pll_multiplier_out      = interp_factor_out;
  assign adc_low_power_out       = low_power_strap_reg;
  assign serial_port_enabled_out = serial_en_strap_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_low_power_held;
    @(posedge clk_sys_in) disable iff (reset_in)
      !$past(reset_in) |-> $stable(adc_low_power_out);
  endproperty
  a_low_power_held: assert property (p_low_power_held)
    else $error("low-power strap changed outside reset");

  property p_strap_full;
    @(posedge clk_sys_in) disable iff (reset_in)
      !serial_en_strap_reg && duplex_strap_reg |=> full_duplex_mode_out;
  endproperty
  a_strap_full: assert property (p_strap_full)
    else $error("duplex strap high did not give full duplex");

  property p_strap_parallel;
    @(posedge clk_sys_in) disable iff (reset_in)
      !serial_en_strap_reg && !duplex_strap_reg && !width_strap_reg
        |=> half_duplex_parallel_mode_out && !full_duplex_mode_out;
  endproperty
  a_strap_parallel: assert property (p_strap_parallel)
    else $error("strap half duplex width low not parallel");

  property p_port_off_quiet;
    @(posedge clk_sys_in) disable iff (reset_in)
      !serial_port_enabled_out |-> !serial_out_pin_oe_out && !wr_strobe;
  endproperty
  a_port_off_quiet: assert property (p_port_off_quiet)
    else $error("serial port active while disabled by strap");

  property p_reg_mode;
    @(posedge clk_sys_in) disable iff (reset_in)
      serial_en_strap_reg && mode_reg[DUPLEX_SELECT_BIT] &&
      !mode_reg[LEGACY_COMPAT_BIT] |=> full_duplex_mode_out;
  endproperty
  a_reg_mode: assert property (p_reg_mode)
    else $error("register duplex bit not applied");

  property p_strap_interp;
    @(posedge clk_sys_in) disable iff (reset_in)
      !serial_en_strap_reg ##1 !$past(reset_in)
        |-> interp_factor_out == $past(interp_strap_reg) &&
            pll_multiplier_out == interp_factor_out;
  endproperty
  a_strap_interp: assert property (p_strap_interp)
    else $error("strap interpolation factor not applied");

  property p_rx_down;
    @(posedge clk_sys_in) disable iff (reset_in)
      receive_powerdown_pin_in
        |=> !adc_clock_enable_out && !rx_bias_enable_out;
  endproperty
  a_rx_down: assert property (p_rx_down)
    else $error("receive path not powered down");

  property p_tx_down;
    @(posedge clk_sys_in) disable iff (reset_in)
      transmit_powerdown_pin_in |=> !dac_clock_enable_out;
  endproperty
  a_tx_down: assert property (p_tx_down)
    else $error("transmit path not powered down");

  property p_dir_low;
    @(posedge clk_sys_in) disable iff (reset_in)
      half_duplex && !direction_pin_in
        |=> !tx_digital_clock_enable_out && data_bus_drive_out;
  endproperty
  a_dir_low: assert property (p_dir_low)
    else $error("receive direction did not stop transmit clock");

  property p_dir_high;
    @(posedge clk_sys_in) disable iff (reset_in)
      half_duplex && direction_pin_in
        |=> !rx_digital_clock_enable_out && !data_bus_drive_out;
  endproperty
  a_dir_high: assert property (p_dir_high)
    else $error("transmit direction did not release the bus");
endmodule

//--- host_model.sv
// Host controller model: strap levels and serial register frames
`timescale 1ns/100ps
module host_model
  import flex_io_cfg_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic sdo_in,
  output logic      select_out,
  output logic      sclk_out,
  output logic      sdata_out,
  output logic      strap_out
);
  ////////////////////////////////////////////////////////////////////////
  // Register settings per mode: FD, opt FD, HALF_DUPLEX_PARALLEL_MODE, opt HALF_DUPLEX_PARALLEL_MODE, HALF_DUPLEX_INTERLEAVED_MODE,
  // opt HALF_DUPLEX_INTERLEAVED_MODE, clone
  localparam logic [2:0] TM [7] = '{TIMING_STANDARD, TIMING_OPT_FULL,
    TIMING_STANDARD, TIMING_OPT_PARALLEL, TIMING_STANDARD,
    TIMING_OPT_INTERLEAV, TIMING_CLONE};
  localparam logic [7:0] MS [7] = '{8'h14, 8'h14, 8'h00, 8'h00, 8'h04,
    8'h04, 8'h01};
  // Interleaved modes never get 1x; HALF_DUPLEX_PARALLEL_MODE shows the 1x case
  localparam logic [1:0] IP [7] = '{INTERP_2X, INTERP_4X, INTERP_1X,
    INTERP_2X, INTERP_2X, INTERP_4X, INTERP_4X};

  initial begin
    select_out = 1'b1;
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    strap_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic set_straps(input logic sel, d, c, o);
    select_out <= sel;
    sdata_out <= d;
    sclk_out <= c;
    strap_out <= o;
  endtask

  // No pull on these lines: strap line inverts once released; with select high, data inverts and clock drops low
  task automatic release_straps();
    strap_out <= ~strap_out;
    if (select_out) begin
      sclk_out <= 1'b0;
      sdata_out <= ~sdata_out;
    end
  endtask

  // Serial clock held 3 cycles per phase so the sampler sees each level
  task automatic frame(input logic rd, input logic [5:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] word;
    word = {rd, 1'b0, addr, wdata};
    rdata = 8'h00;
    @(negedge clk_sys_in);
    select_out <= 1'b0;
    for (int b = 15; b >= 0; b--) begin
      sdata_out <= word[b];
      repeat (3) @(negedge clk_sys_in);
      if (b < 8) rdata[b] = sdo_in;
      sclk_out <= 1'b1;
      repeat (3) @(negedge clk_sys_in);
      sclk_out <= 1'b0;
    end
    sdata_out <= ~word[0];
    select_out <= 1'b1;
    repeat (2) @(negedge clk_sys_in);
  endtask

  task automatic config_mode(input int i, output logic [2:0] tm,
                             output logic [1:0] ip);
    logic [7:0] dummy;
    tm = TM[i];
    ip = IP[i];
    frame(1'b0, ADDR_INTERFACE_TIMING_CONTROL, {tm, 5'h00}, dummy);
    frame(1'b0, ADDR_IO_MODE_SELECT, MS[i], dummy);
    frame(1'b0, ADDR_IO_FORMAT_INTERPOLATION, {6'h00, ip}, dummy);
  endtask
endmodule

//--- tb.sv
// Self-checking testbench for the flexible-port configuration loader
`timescale 1ns/100ps
module tb;
  import flex_io_cfg_pkg::*;
  logic       clk_sys_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       adc_lp = 1'b0, flex_control_pin_two = 1'b0, rxpd = 1'b0, txpd = 1'b0;
  logic       dir = 1'b0;
  logic       sel, sclk, sdata, strap, sdo_out, sdo_oe;
  logic       lp_o, en_o, fd_o, half_duplex_parallel_mode_o, half_duplex_interleaved_mode_o, cl_o, err_o;
  logic [2:0] tm_o;
  logic [1:0] ip_o, pll_o;
  logic       adck, rxb, dack, txb, rxd, txd, drv;
  wire        sdo_wire = sdo_oe ? sdo_out : strap;
  int         fails = 0;
  int         n_tests = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  host_model host (.clk_sys_in(clk_sys_in), .sdo_in(sdo_wire),
    .select_out(sel), .sclk_out(sclk), .sdata_out(sdata),
    .strap_out(strap));

  flex_io_mode_config dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .adc_low_power_strap_in(adc_lp), .serial_select_pin_in(sel),
    .serial_clock_pin_in(sclk), .serial_data_pin_in(sdata),
    .serial_out_pin_in(sdo_wire), .serial_out_pin_out(sdo_out),
    .serial_out_pin_oe_out(sdo_oe), .flex_control_pin_two_in(flex_control_pin_two),
    .receive_powerdown_pin_in(rxpd), .transmit_powerdown_pin_in(txpd),
    .direction_pin_in(dir), .adc_low_power_out(lp_o),
    .serial_port_enabled_out(en_o), .full_duplex_mode_out(fd_o),
    .half_duplex_parallel_mode_out(half_duplex_parallel_mode_o),
    .half_duplex_interleaved_mode_out(half_duplex_interleaved_mode_o), .clone_mode_out(cl_o),
    .timing_mode_out(tm_o), .interp_factor_out(ip_o),
    .pll_multiplier_out(pll_o), .interp_config_error_out(err_o),
    .adc_clock_enable_out(adck), .rx_bias_enable_out(rxb),
    .dac_clock_enable_out(dack), .tx_bias_enable_out(txb),
    .rx_digital_clock_enable_out(rxd), .tx_digital_clock_enable_out(txd),
    .data_bus_drive_out(drv));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // Mode nibble is {full, half_duplex_parallel_mode, half_duplex_interleaved_mode, clone}
  task automatic chk_mode(input logic [3:0] m, input logic [2:0] tm,
                          input logic [1:0] ip, input logic err);
    chk({4'h0, fd_o, half_duplex_parallel_mode_o, half_duplex_interleaved_mode_o, cl_o}, {4'h0, m});
    chk({5'h00, tm_o}, {5'h00, tm});
    chk({ip_o, pll_o, 3'h0, err_o}, {ip, ip, 3'h0, err});
  endtask

  task automatic do_reset(input logic lp, s, d, c, o, w);
    @(negedge clk_sys_in);
    reset_in = 1'b1;
    adc_lp = lp;
    flex_control_pin_two = w;
    host.set_straps(s, d, c, o);
    repeat (3) @(negedge clk_sys_in);
    reset_in = 1'b0;
    @(negedge clk_sys_in);
    host.release_straps();
    repeat (3) @(negedge clk_sys_in);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Strap decode, then pins moved after release must not change anything
  task automatic strap_modes();
    logic [3:0] t [4] = '{4'h0, 4'h3, 4'hc, 4'h7};
    logic [1:0] ip [4] = '{INTERP_1X, INTERP_2X, INTERP_4X, INTERP_2X};
    logic [3:0] m [4] = '{4'h4, 4'h2, 4'h8, 4'h8};
    for (int i = 0; i < 4; i++) begin
      do_reset(~t[i][3] ^ t[i][0], 1'b0, ip[i][1], ip[i][0], t[i][2],
               t[i][1]);
      chk({6'h00, lp_o, en_o}, {6'h00, ~t[i][3] ^ t[i][0], 1'b0});
      chk_mode(m[i], TIMING_STANDARD, ip[i], 1'b0);
      adc_lp = ~adc_lp;
      flex_control_pin_two = ~flex_control_pin_two;
      repeat (3) @(negedge clk_sys_in);
      chk({7'h00, lp_o}, {7'h00, ~t[i][3] ^ t[i][0]});
      chk_mode(m[i], TIMING_STANDARD, ip[i], 1'b0);
    end
  endtask

  // Every pin combination; direction only counts in half duplex
  task automatic power_pins(input logic full);
    logic [2:0] v;
    for (int k = 0; k < 8; k++) begin
      v = k[2:0];
      {dir, rxpd, txpd} = v;
      repeat (2) @(negedge clk_sys_in);
      chk({4'h0, adck, rxb, dack, txb},
          {4'h0, ~v[1], ~v[1], ~v[0], ~v[0]});
      chk({5'h00, rxd, txd, drv}, {5'h00, full | ~v[2], full | v[2],
          full | ~v[2]});
    end
  endtask

  // Duplex, width and interpolation straps ignored with the port on; each documented mode programmed
  task automatic serial_modes();
    logic [3:0] m [7] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1};
    logic [2:0] tm;
    logic [1:0] ip;
    logic [7:0] rd;
    do_reset(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    chk({7'h00, en_o}, 8'h01);
    chk_mode(4'h4, TIMING_STANDARD, INTERP_1X, 1'b0);
    for (int i = 0; i < 7; i++) begin
      host.config_mode(i, tm, ip);
      repeat (4) @(negedge clk_sys_in);
      chk_mode(m[i], tm, ip, 1'b0);
    end
    // Host breaks the interpolation rule on purpose in clone mode
    host.frame(1'b0, ADDR_IO_FORMAT_INTERPOLATION, 8'h00, rd);
    repeat (4) @(negedge clk_sys_in);
    chk_mode(4'h1, TIMING_CLONE, INTERP_1X, 1'b1);
    host.frame(1'b1, ADDR_IO_MODE_SELECT, 8'h00, rd);
    chk(rd, 8'h01);
    host.frame(1'b1, ADDR_INTERFACE_TIMING_CONTROL, 8'h00, rd);
    chk(rd, 8'he0);
    host.frame(1'b0, 6'h20, 8'h5a, rd);
    host.frame(1'b1, 6'h20, 8'h00, rd);
    chk(rd, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles; this limit is generous
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    fails++;
    give_verdict();
  end

  initial begin
    strap_modes();
    power_pins(1'b1);
    do_reset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    power_pins(1'b0);
    {dir, rxpd, txpd} = 3'h0;
    serial_modes();
    give_verdict();
  end
endmodule
